// file: logic/wtst_counter.sv
// The 32-bit down counter of the watchdog with load and decrement controls.
// Assumes load and decrement come from logic on the same clock; load has priority.
`timescale 1ns/1ps
`default_nettype none
module wtst_counter #(
    parameter int unsigned              CNT_W   = wtst_pkg::DATA_W,
    parameter logic [CNT_W-1:0]         RST_VAL = wtst_pkg::RST_COUNT_VALUE
) (
    input  wire logic                   I_CLK,
    input  wire logic                   I_RESET,
    input  wire logic                   i_load,
    input  wire logic [CNT_W-1:0]       i_load_value,
    input  wire logic                   i_dec,
    output logic      [CNT_W-1:0]       o_count,
    output logic                        o_zero
);
    // ==========================================================
    // Counter state
    // ==========================================================
    logic [CNT_W-1:0] count_ff;     // Present count.
    logic [CNT_W-1:0] nxt_count;    // Next count.

    // A load wins over a decrement, so a reload at zero never wraps.
    always_comb begin
        nxt_count = count_ff;
        if (i_load) begin
            nxt_count = i_load_value;               // see [RULE1]
        end else if (i_dec) begin
            nxt_count = count_ff - 1'b1;            // see [RULE1]
        end
    end

    // Registers the count.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            count_ff <= RST_VAL;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign o_count = count_ff;
    assign o_zero  = (count_ff == '0);

    // ==========================================================
    // Checks
    // ==========================================================
    dec_step_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE1]
        (i_dec && !i_load) |=> (count_ff == $past(count_ff) - 1'b1))
        else $error("Counter did not step down by one.");
    load_take_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE1]
        i_load |=> (count_ff == $past(i_load_value)))
        else $error("Counter did not take the load value.");
endmodule // wtst_counter
`default_nettype wire

// file: logic/wtst_pkg.sv
// Constants shared by the two-stage watchdog: register offsets, field positions and reset values.
// Assumes a 32-bit Avalon-MM register bus with byte addresses and one aligned word per register.
`default_nettype none
package wtst_pkg;
    // ==========================================================
    // Widths
    // ==========================================================
    localparam int unsigned DATA_W = 32;             // Bus and counter width.
    localparam int unsigned ADDR_W = 12;             // Byte address width of the register window.

    // ==========================================================
    // Register offsets (byte addresses)
    // ==========================================================
    localparam logic [11:0] OFS_WD_RELOAD_VALUE       = 12'h000; // Reload value.
    localparam logic [11:0] OFS_WD_COUNT_VALUE        = 12'h004; // Current count, read only.
    localparam logic [11:0] OFS_WD_CONTROL            = 12'h008; // Start and reset enables.
    localparam logic [11:0] OFS_WD_IRQ_CLEAR          = 12'h00c; // Write only clear and reload.
    localparam logic [11:0] OFS_WD_RAW_IRQ_STATUS     = 12'h010; // Raw pending flag.
    localparam logic [11:0] OFS_WD_MASKED_IRQ_STATUS  = 12'h014; // Raw flag gated by enable.
    localparam logic [11:0] OFS_WD_STALL_CONTROL      = 12'h418; // Debug stall enable.
    localparam logic [11:0] OFS_WD_LOCK_KEY           = 12'hc00; // Lock and unlock key.

    // ==========================================================
    // Field positions and values
    // ==========================================================
    localparam int unsigned CTL_IRQ_START_BIT  = 0;  // Starts counting and enables the interrupt.
    localparam int unsigned CTL_RESET_OUT_BIT  = 1;  // Enables the reset output.
    localparam int unsigned STALL_ENABLE_BIT   = 0;  // Stops counting while debug halt is high.
    localparam int unsigned STATUS_BIT         = 0;  // Position of the status flags.
    localparam logic [31:0] UNLOCK_KEY         = 32'h1acce551; // Only value that unlocks.
    localparam logic [31:0] RST_RELOAD_VALUE   = 32'hffffffff; // Reload register after reset.
    localparam logic [31:0] RST_COUNT_VALUE    = 32'hffffffff; // Counter after reset.
    localparam logic [31:0] ZERO_WORD          = 32'h00000000; // Reads of empty locations.
    localparam logic [31:0] LOCKED_READ_VALUE  = 32'h00000001; // Lock register read while locked.
endpackage
`default_nettype wire

// file: logic/wtst_top.sv
// Two-stage watchdog: interrupt on first time-out, system reset on the second.
// Assumes an Avalon-MM master on I_CLK, a gating enable and debug halt from same-clock logic.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] 32-bit down counter loaded from reload register.
// [RULE2] Zero while enabled gives first time-out interrupt.
// [RULE3] First time-out reloads counter and keeps counting.
// [RULE4] Second zero, flag pending, reset enabled: reset.
// [RULE5] Clear before second zero reloads and resumes.
// [RULE6] Reload write loads counter at once, counting continues.
// [RULE7] Reload write leaves pending interrupt set.
// [RULE8] Only clear-register write removes pending interrupt.
// [RULE9] Interrupt and reset have separate enables.
// [RULE10] Enabling interrupt presets counter from reload.
// [RULE11] Time-out interrupt is nonmaskable; status masking exists.
// [RULE12] Counting only while watchdog clock enable high.
// [RULE13] Stall enabled: no counting during debug halt.
// [RULE14] Software enables watchdog clock gate first.
// [RULE15] Software writes reload, reset enable, then start.
// [RULE16] Start bit runs watchdog and locks control.
// [RULE17] Any lock-register write other than the key locks all other registers.
// [RULE18] Only the key value unlocks the registers.
// [RULE19] Writing zero reload raises interrupt at once.
// [RULE20] Clear write clears interrupt and reloads counter.
// [RULE21] Control writes ignored after start until reset.
// [RULE22] Masked status is raw flag AND enable.
// [RULE23] Before start: counter holds, no interrupt, reset.
// [RULE24] Raw flag sticky until cleared; qualifies reset.
module wtst_top (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    input  wire logic [11:0] I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    output logic      [31:0] O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST,
    input  wire logic        I_WD_CLK_EN,
    input  wire logic        I_DBG_HALT,
    output logic             O_WD_NMI,
    output logic             O_SYS_RESET
);
    // ==========================================================
    // Declarations
    // ==========================================================
    logic        ack_ff;            // High in the cycle a request is answered.
    logic        nxt_ack;           // Next answer flag.
    logic [31:0] rdata_ff;          // Registered read data.
    logic [31:0] nxt_rdata;         // Next read data.
    logic [31:0] reload_ff;         // Reload value register.
    logic [31:0] nxt_reload;        // Next reload value.
    logic        irq_start_enable_ff;   // Start and interrupt enable, sticky.
    logic        nxt_irq_start_enable;  // Next start enable.
    logic        reset_out_enable_ff;   // Reset output enable.
    logic        nxt_reset_out_enable;  // Next reset enable.
    logic        stall_en_ff;       // Debug stall enable.
    logic        nxt_stall_en;      // Next stall enable.
    logic        locked_ff;         // All registers but the lock register locked.
    logic        nxt_locked;        // Next lock state.
    logic        raw_irq_ff;        // Sticky time-out flag.
    logic        nxt_raw_irq;       // Next time-out flag.
    logic        sys_reset_ff;      // Reset request to the system.
    logic        nxt_sys_reset;     // Next reset request.
    logic        req;               // A read or write is on the bus.
    logic        wr_go;             // Write takes effect this cycle.
    logic        wr_open;           // Write takes effect and registers are unlocked.
    logic        wr_reload;         // Accepted write to the reload register.
    logic        wr_clear;          // Accepted write to the clear register.
    logic        start_now;         // Start bit set by this write.
    logic        tick;              // Counter may step this cycle.
    logic        timeout;           // Counter is at zero on a tick.
    logic        cnt_load;          // Counter loads this cycle.
    logic [31:0] cnt_load_value;    // Value the counter loads.
    logic [31:0] count;             // Present count.
    logic        cnt_zero;          // Count is zero.

    // ==========================================================
    // Avalon-MM slave handshake
    // ==========================================================
    assign req               = I_AVS_READ | I_AVS_WRITE;
    assign O_AVS_WAITREQUEST = req & ~ack_ff;   // One wait cycle, then the answer.
    assign wr_go             = I_AVS_WRITE & ack_ff;
    assign wr_open           = wr_go & ~locked_ff;                                  // see [RULE17]
    assign wr_reload         = wr_open & (I_AVS_ADDRESS == wtst_pkg::OFS_WD_RELOAD_VALUE);
    assign wr_clear          = wr_open & (I_AVS_ADDRESS == wtst_pkg::OFS_WD_IRQ_CLEAR); // see [RULE8]

    // Answers every request after exactly one wait cycle and preloads the read data.
    always_comb begin
        nxt_ack   = req & ~ack_ff;
        nxt_rdata = rdata_ff;
        if (req && !ack_ff) begin
            case (I_AVS_ADDRESS)
                wtst_pkg::OFS_WD_RELOAD_VALUE: begin
                    nxt_rdata = reload_ff;
                end
                wtst_pkg::OFS_WD_COUNT_VALUE: begin
                    nxt_rdata = count;
                end
                wtst_pkg::OFS_WD_CONTROL: begin
                    nxt_rdata = wtst_pkg::ZERO_WORD;
                    nxt_rdata[wtst_pkg::CTL_IRQ_START_BIT] = irq_start_enable_ff;
                    nxt_rdata[wtst_pkg::CTL_RESET_OUT_BIT] = reset_out_enable_ff;
                end
                wtst_pkg::OFS_WD_RAW_IRQ_STATUS: begin
                    nxt_rdata = wtst_pkg::ZERO_WORD;
                    nxt_rdata[wtst_pkg::STATUS_BIT] = raw_irq_ff;
                end
                wtst_pkg::OFS_WD_MASKED_IRQ_STATUS: begin
                    nxt_rdata = wtst_pkg::ZERO_WORD;
                    nxt_rdata[wtst_pkg::STATUS_BIT] = raw_irq_ff & irq_start_enable_ff; // see [RULE22] [RULE11]
                end
                wtst_pkg::OFS_WD_STALL_CONTROL: begin
                    nxt_rdata = wtst_pkg::ZERO_WORD;
                    nxt_rdata[wtst_pkg::STALL_ENABLE_BIT] = stall_en_ff;
                end
                wtst_pkg::OFS_WD_LOCK_KEY: begin
                    nxt_rdata = locked_ff ? wtst_pkg::LOCKED_READ_VALUE : wtst_pkg::ZERO_WORD;
                end
                default: begin
                    nxt_rdata = wtst_pkg::ZERO_WORD; // Clear register and unmapped words read zero.
                end
            endcase
        end
    end

    // Registers the handshake and read data.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ack_ff   <= 1'b0;
            rdata_ff <= wtst_pkg::ZERO_WORD;
        end else begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign O_AVS_READDATA = rdata_ff;

    // ==========================================================
    // Counter control
    // ==========================================================
    // The counter steps only when started, the watchdog clock is on and no stall holds it.
    assign tick = irq_start_enable_ff & I_WD_CLK_EN                      // see [RULE12] [RULE23]
                & ~(stall_en_ff & I_DBG_HALT);                           // see [RULE13]
    assign timeout   = tick & cnt_zero;                                  // see [RULE2]
    assign start_now = wr_open & (I_AVS_ADDRESS == wtst_pkg::OFS_WD_CONTROL)
                     & ~irq_start_enable_ff & I_AVS_WRITEDATA[wtst_pkg::CTL_IRQ_START_BIT];
    // Reload on a new value, a clear, a start or a time-out.
    assign cnt_load = wr_reload                                          // see [RULE6]
                    | wr_clear                                           // see [RULE20] [RULE5]
                    | start_now                                          // see [RULE10]
                    | timeout;                                           // see [RULE3]
    assign cnt_load_value = wr_reload ? I_AVS_WRITEDATA : reload_ff;

    wtst_counter #(
        .CNT_W   (wtst_pkg::DATA_W),
        .RST_VAL (wtst_pkg::RST_COUNT_VALUE)
    ) u_counter (
        .I_CLK        (I_CLK),
        .I_RESET      (I_RESET),
        .i_load       (cnt_load),
        .i_load_value (cnt_load_value),
        .i_dec        (tick),
        .o_count      (count),
        .o_zero       (cnt_zero)
    );

    // ==========================================================
    // Configuration, lock and status
    // ==========================================================
    // Computes the register updates; hardware sets of the flag win over a clear.
    always_comb begin
        nxt_reload           = reload_ff;
        nxt_irq_start_enable = irq_start_enable_ff;
        nxt_reset_out_enable = reset_out_enable_ff;
        nxt_stall_en         = stall_en_ff;
        nxt_locked           = locked_ff;
        nxt_raw_irq          = raw_irq_ff;
        nxt_sys_reset        = sys_reset_ff;
        if (wr_reload) begin
            nxt_reload = I_AVS_WRITEDATA;                                // see [RULE1]
        end
        // Control is frozen once started; only a hardware reset reopens it.
        if (wr_open && (I_AVS_ADDRESS == wtst_pkg::OFS_WD_CONTROL) && !irq_start_enable_ff) begin // see [RULE21]
            nxt_irq_start_enable = I_AVS_WRITEDATA[wtst_pkg::CTL_IRQ_START_BIT]; // see [RULE16]
            nxt_reset_out_enable = I_AVS_WRITEDATA[wtst_pkg::CTL_RESET_OUT_BIT]; // see [RULE9]
        end
        if (wr_open && (I_AVS_ADDRESS == wtst_pkg::OFS_WD_STALL_CONTROL)) begin
            nxt_stall_en = I_AVS_WRITEDATA[wtst_pkg::STALL_ENABLE_BIT];
        end
        // The lock register stays writable while locked, or it could never unlock.
        if (wr_go && (I_AVS_ADDRESS == wtst_pkg::OFS_WD_LOCK_KEY)) begin
            nxt_locked = (I_AVS_WRITEDATA != wtst_pkg::UNLOCK_KEY);      // see [RULE17] [RULE18]
        end
        // A reload write never clears the flag; only the clear register does.
        if (wr_clear) begin
            nxt_raw_irq = 1'b0;                                          // see [RULE8] [RULE7]
        end
        if (timeout
            || (wr_reload && irq_start_enable_ff && (I_AVS_WRITEDATA == wtst_pkg::ZERO_WORD))) begin // see [RULE19]
            nxt_raw_irq = 1'b1;                                          // see [RULE24]
        end
        // Second time-out with the flag still pending asserts reset until hardware reset.
        if (timeout && raw_irq_ff && reset_out_enable_ff) begin
            nxt_sys_reset = 1'b1;                                        // see [RULE4] [RULE24]
        end
    end

    // Registers configuration and status.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            reload_ff           <= wtst_pkg::RST_RELOAD_VALUE;
            irq_start_enable_ff <= 1'b0;
            reset_out_enable_ff <= 1'b0;
            stall_en_ff         <= 1'b0;
            locked_ff           <= 1'b0;
            raw_irq_ff          <= 1'b0;
            sys_reset_ff        <= 1'b0;
        end else begin
            reload_ff           <= nxt_reload;
            irq_start_enable_ff <= nxt_irq_start_enable;
            reset_out_enable_ff <= nxt_reset_out_enable;
            stall_en_ff         <= nxt_stall_en;
            locked_ff           <= nxt_locked;
            raw_irq_ff          <= nxt_raw_irq;
            sys_reset_ff        <= nxt_sys_reset;
        end
    end

    // The processor line has no mask of its own: it follows the pending flag while started.
    assign O_WD_NMI    = raw_irq_ff & irq_start_enable_ff;               // see [RULE11]
    assign O_SYS_RESET = sys_reset_ff;

    // ==========================================================
    // Checks
    // ==========================================================
    bus_answer_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (req && O_AVS_WAITREQUEST) |=> !O_AVS_WAITREQUEST)
        else $error("Bus request not answered after one wait cycle.");
    first_timeout_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE2]
        timeout |=> raw_irq_ff && O_WD_NMI)
        else $error("Time-out did not raise the interrupt.");
    timeout_reload_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE3]
        (timeout && !wr_reload) |=> (count == $past(reload_ff)))
        else $error("Time-out did not reload the counter.");
    second_reset_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE4]
        $rose(sys_reset_ff) |-> $past(timeout && raw_irq_ff && reset_out_enable_ff))
        else $error("Reset raised without a qualified second time-out.");
    clear_reload_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE20]
        (wr_clear && !timeout) |=> !raw_irq_ff && (count == $past(reload_ff)))
        else $error("Clear write did not clear and reload.");
    reload_keeps_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE7]
        (wr_reload && raw_irq_ff) |=> raw_irq_ff && (count == $past(I_AVS_WRITEDATA)))
        else $error("Reload write lost the flag or the value.");
    ctl_frozen_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE21]
        irq_start_enable_ff |=> irq_start_enable_ff && $stable(reset_out_enable_ff))
        else $error("Control changed after start.");
    idle_quiet_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE23]
        (!irq_start_enable_ff && !cnt_load) |=> $stable(count) && !raw_irq_ff && !O_SYS_RESET)
        else $error("Watchdog acted before start.");
    stall_hold_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE13]
        (stall_en_ff && I_DBG_HALT && !cnt_load) |=> $stable(count))
        else $error("Counter moved during debug stall.");
    locked_hold_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE17]
        (locked_ff && wr_go && (I_AVS_ADDRESS == wtst_pkg::OFS_WD_RELOAD_VALUE)) |=> $stable(reload_ff))
        else $error("Locked reload register changed.");
    unlock_key_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // see [RULE18]
        (wr_go && (I_AVS_ADDRESS == wtst_pkg::OFS_WD_LOCK_KEY))
        |=> (locked_ff == ($past(I_AVS_WRITEDATA) != wtst_pkg::UNLOCK_KEY)))
        else $error("Lock state does not follow the key.");
endmodule // wtst_top
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the two-stage watchdog.
// Assumes the design answers each bus request after one wait cycle.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, rst, rd, wr, clk_en, halt; // Driven inputs.
    logic [11:0] addr;                            // Bus address.
    logic [31:0] wdata, rv;                       // Write data and last read.
    wire  logic [31:0] rdata;                     // Read data.
    wire  logic  wrq, nmi, srst, seen;            // Design and partner outputs.
    wire  logic [7:0] ncnt;                       // Interrupt entries.
    int          bad_count = 0, checks_done = 0, n;
    wtst_top wtst_top_inst (.I_CLK(clk), .I_RESET(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wrq),
        .I_WD_CLK_EN(clk_en), .I_DBG_HALT(halt), .O_WD_NMI(nmi), .O_SYS_RESET(srst));
    wtst_partner wtst_partner_inst (.I_CLK(clk), .i_clear(rst), .i_nmi(nmi), .i_sys_reset(srst),
        .o_nmi_count(ncnt), .o_reset_seen(seen));
    // ==========================================================
    // Clock, watchdog and shared tasks
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cuts a hang short; the whole run needs well under 2000 cycles.
    initial begin
        #50000;
        bad_count++;
        results();
    end
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One bus cycle: hold the request until waitrequest is seen low, then release.
    // The wait is open ended on purpose: only the watchdog process may end a hang.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        rd    <= !w;
        wr    <= w;
        do begin
            @(posedge clk);
        end while (wrq !== 1'b0);
        rv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Counts edges until the interrupt (sel 0) or the reset (sel 1) is seen high.
    task automatic wait_hi(input logic sel);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((sel ? srst : nmi) !== 1'b1 && n < 200);
    endtask
    // Resets the design for 5 cycles with the watchdog clock running.
    task automatic do_reset();
        rst    <= 1'b1;
        rd     <= 1'b0;
        wr     <= 1'b0;
        clk_en <= 1'b1;
        halt   <= 1'b0;
        addr   <= 12'h000;
        wdata  <= 32'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    // Reset values, holding before start, locking and the unmapped space.
    task automatic t_lock();
        do_reset();
        bus(0, wtst_pkg::OFS_WD_COUNT_VALUE, 32'h0);
        chk(rv, 32'hffffffff, "count at reset");
        bus(0, wtst_pkg::OFS_WD_COUNT_VALUE, 32'h0);
        chk(rv, 32'hffffffff, "count held");
        bus(0, wtst_pkg::OFS_WD_CONTROL, 32'h0);
        chk(rv, 32'h0, "control at reset");
        bus(1, wtst_pkg::OFS_WD_LOCK_KEY, 32'h0);
        bus(1, wtst_pkg::OFS_WD_RELOAD_VALUE, 32'h5);
        bus(0, wtst_pkg::OFS_WD_RELOAD_VALUE, 32'h0);
        chk(rv, 32'hffffffff, "locked reload");
        bus(0, wtst_pkg::OFS_WD_LOCK_KEY, 32'h0);
        chk(rv, 32'h1, "lock state");
        bus(1, wtst_pkg::OFS_WD_LOCK_KEY, 32'h1acce550);
        bus(0, wtst_pkg::OFS_WD_LOCK_KEY, 32'h0);
        chk(rv, 32'h1, "near key");
        bus(1, wtst_pkg::OFS_WD_LOCK_KEY, wtst_pkg::UNLOCK_KEY);
        bus(0, wtst_pkg::OFS_WD_LOCK_KEY, 32'h0);
        chk(rv, 32'h0, "unlocked");
        bus(1, wtst_pkg::OFS_WD_RELOAD_VALUE, 32'h5);
        bus(0, wtst_pkg::OFS_WD_RELOAD_VALUE, 32'h0);
        chk(rv, 32'h5, "reload written");
        bus(0, 12'h020, 32'h0);
        chk(rv, 32'h0, "unmapped read");
        chk({31'h0, nmi}, 32'h0, "no interrupt before start");
        bus(1, wtst_pkg::OFS_WD_CONTROL, 32'h1);
        bus(1, wtst_pkg::OFS_WD_RELOAD_VALUE, 32'h0);
        wait_hi(1'b0);
        chk(n, 32'h1, "zero reload interrupt");
        $display("test lock and zero reload done");
    endtask
    // Two time-outs with reset enabled; control frozen once started.
    task automatic t_two_stage();
        do_reset();
        bus(1, wtst_pkg::OFS_WD_RELOAD_VALUE, 32'h2);
        bus(1, wtst_pkg::OFS_WD_CONTROL, 32'h3);
        wait_hi(1'b0);
        chk(n, 32'h3, "first time-out");
        wait_hi(1'b1);
        chk(n, 32'h3, "second time-out reset");
        // The partner registers the reset one edge later, so it is looked at after a bus cycle.
        bus(0, wtst_pkg::OFS_WD_MASKED_IRQ_STATUS, 32'h0);
        chk(rv, 32'h1, "masked status");
        chk({31'h0, seen}, 32'h1, "partner saw reset");
        bus(1, wtst_pkg::OFS_WD_CONTROL, 32'h0);
        bus(0, wtst_pkg::OFS_WD_CONTROL, 32'h0);
        chk(rv, 32'h3, "control frozen");
        $display("test two stage done");
    endtask
    // Clearing before the second time-out; reload writes keep the flag.
    task automatic t_clear();
        do_reset();
        bus(1, wtst_pkg::OFS_WD_RELOAD_VALUE, 32'h14);
        bus(1, wtst_pkg::OFS_WD_CONTROL, 32'h3);
        wait_hi(1'b0);
        chk(n, 32'h15, "time-out of 20");
        bus(1, wtst_pkg::OFS_WD_RELOAD_VALUE, 32'h14);
        chk({31'h0, nmi}, 32'h1, "flag kept");
        bus(1, wtst_pkg::OFS_WD_IRQ_CLEAR, 32'h0);
        chk({31'h0, nmi}, 32'h0, "flag cleared");
        repeat (30) @(posedge clk);
        chk({30'h0, srst, nmi}, 32'h1, "resumed after clear");
        chk({24'h0, ncnt}, 32'h2, "two entries");
        $display("test clear done");
    endtask
    // Clock gating and debug stall both stop the count.
    task automatic t_stall();
        do_reset();
        clk_en <= 1'b0;
        bus(1, wtst_pkg::OFS_WD_STALL_CONTROL, 32'h1);
        bus(1, wtst_pkg::OFS_WD_RELOAD_VALUE, 32'h64);
        bus(1, wtst_pkg::OFS_WD_CONTROL, 32'h1);
        bus(0, wtst_pkg::OFS_WD_COUNT_VALUE, 32'h0);
        chk(rv, 32'h64, "gated and preset");
        halt   <= 1'b1;
        clk_en <= 1'b1;
        bus(0, wtst_pkg::OFS_WD_COUNT_VALUE, 32'h0);
        chk(rv, 32'h64, "stalled");
        halt <= 1'b0;
        // Read data are taken one edge after the request, so two free ticks give a known count.
        repeat (2) @(posedge clk);
        bus(0, wtst_pkg::OFS_WD_COUNT_VALUE, 32'h0);
        chk(rv, 32'h62, "counting again");
        $display("test stall done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        t_lock();
        t_two_stage();
        t_clear();
        t_stall();
        results();
    end
endmodule // tb
`default_nettype wire

// file: tb/wtst_partner.sv
// Model of the interrupt controller and system reset logic beside the watchdog.
// Assumes the watchdog outputs are level signals on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wtst_partner (
    input  wire logic       I_CLK,
    input  wire logic       i_clear,
    input  wire logic       i_nmi,
    input  wire logic       i_sys_reset,
    output logic      [7:0] o_nmi_count,
    output logic            o_reset_seen
);
    logic nmi_q_ff; // Last level of the interrupt, for edge detection.
    // ==========================================================
    // Interrupt entry and reset capture
    // ==========================================================
    // The interrupt has no mask here, so every rise is an entry.
    always_ff @(posedge I_CLK) begin
        nmi_q_ff <= i_nmi;
        if (i_clear) begin
            o_nmi_count  <= 8'h00;
            o_reset_seen <= 1'b0;
        end else begin
            if (i_nmi && !nmi_q_ff) begin
                o_nmi_count <= o_nmi_count + 8'h01;
            end
            if (i_sys_reset) begin
                o_reset_seen <= 1'b1;
            end
        end
    end
endmodule // wtst_partner
`default_nettype wire
